// file: src/spimcs_defines.vh
// constants shared by the chip-select control block
`ifndef SPIMCS_DEFINES_VH
`define SPIMCS_DEFINES_VH

// transmit word layout
`define SPIMCS_TD_LSB        0
`define SPIMCS_TD_MSB        15
`define SPIMCS_SEL_LSB       16
`define SPIMCS_SEL_MSB       19
`define SPIMCS_FINAL_BIT     24
`define SPIMCS_WORD_W        32

// select lines and word length
`define SPIMCS_SEL_IDLE      4'hF
`define SPIMCS_BITS_MIN      5'd8
`define SPIMCS_BITS_MAX      5'd16
`define SPIMCS_BITS_TOP      4'h8

// state codes
`define SPIMCS_ST_IDLE       3'd0
`define SPIMCS_ST_LEAD       3'd1
`define SPIMCS_ST_SHIFT      3'd2
`define SPIMCS_ST_WGAP       3'd3
`define SPIMCS_ST_HOLD       3'd4
`define SPIMCS_ST_CSGAP      3'd5

// timing: serial clock half period and least select gap, in mclk cycles
`define SPIMCS_HALF_CYC      9'd4
`define SPIMCS_MIN_GAP_CYC   9'd1

`endif

// file: src/spimcs_sync2.v
// two flip-flop synchroniser for a level from another domain
`timescale 1ns/1ns
`default_nettype none
module spimcs_sync2 (
  input  wire mclk_i,
  input  wire resetn_i,
  input  wire async_i,
  output wire sync_o
);
  reg meta_ff;
  reg sync_ff;

  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule
`default_nettype wire

// file: src/spimcs_buf2.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module spimcs_buf2 #(
  parameter W = 32
) (
  input  wire         mclk_i,
  input  wire         resetn_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] ent0_ff;
  reg [W-1:0] ent1_ff;
  reg [1:0]   cnt_ff;
  reg         ready_ff;

  wire push = in_valid_i & ready_ff;
  wire pop  = out_ready_i & (cnt_ff != 2'd0);
  reg  [1:0] nxt_cnt;

  always @* begin
    nxt_cnt = cnt_ff;
    if (push & ~pop) begin
      nxt_cnt = cnt_ff + 2'd1;
    end else if (pop & ~push) begin
      nxt_cnt = cnt_ff - 2'd1;
    end
  end

  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ent0_ff  <= {W{1'b0}};
      ent1_ff  <= {W{1'b0}};
      cnt_ff   <= 2'd0;
      ready_ff <= 1'b1;
    end else begin
      // entry 0 is always the head
      if (pop) begin
        ent0_ff <= (cnt_ff == 2'd2) ? ent1_ff : in_data_i;
      end else if (push & (cnt_ff == 2'd0)) begin
        ent0_ff <= in_data_i;
      end
      if (push & ((cnt_ff == 2'd1 & ~pop) | (cnt_ff == 2'd2))) begin
        ent1_ff <= in_data_i;
      end
      cnt_ff   <= nxt_cnt;
      ready_ff <= (nxt_cnt != 2'd2);
    end
  end

  assign in_ready_o  = ready_ff;
  assign out_valid_o = (cnt_ff != 2'd0);
  assign out_data_o  = ent0_ff;
endmodule
`default_nettype wire

// file: src/spimcs_top.v
// serial master chip-select control with word shifter
`timescale 1ns/1ns
`include "spimcs_defines.vh"
`default_nettype none

module spimcs_top (
  input  wire        mclk_i,
  input  wire        resetn_i,
  input  wire        enable_i,
  input  wire        select_mode_bit_i,
  input  wire        select_decode_enable_i,
  input  wire [3:0]  slave_select_field_i,
  input  wire        dma_halfword_i,
  input  wire [7:0]  inter_select_delay_i,
  input  wire [15:0] word_bits_i,
  input  wire [3:0]  keep_select_active_i,
  input  wire [3:0]  force_select_release_i,
  input  wire [31:0] inter_word_delay_i,
  input  wire        final_word_cmd_i,
  input  wire        tx_valid_i,
  output wire        tx_ready_o,
  input  wire [31:0] tx_data_i,
  output wire        tx_holding_empty_o,
  input  wire        miso_i,
  output wire        sclk_o,
  output wire        mosi_o,
  output wire [3:0]  select_lines_o,
  output wire [15:0] rx_data_o,
  output wire        rx_valid_o,
  output wire        busy_o
);
  //////////////////////////////////////////////////////////////////////////
  // input buffer and miso synchroniser

  wire        buf_valid;
  wire [31:0] buf_data;
  wire        buf_in_ready;
  wire        miso_s;
  reg         do_pop;

  spimcs_buf2 #(
    .W (`SPIMCS_WORD_W)
  ) u_buf (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (tx_data_i),
    .out_valid_o (buf_valid),
    .out_ready_i (do_pop),
    .out_data_o  (buf_data)
  );

  spimcs_sync2 u_miso (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .async_i  (miso_i),
    .sync_o   (miso_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // head word decode

  reg [2:0]  state_ff;
  reg [8:0]  cnt_ff;
  reg [3:0]  sel_ff;
  reg        sclk_ff;
  reg        mosi_ff;
  reg [15:0] sh_ff;
  reg [15:0] rx_ff;
  reg [4:0]  bit_ff;
  reg [1:0]  cur_cfg_ff;
  reg        cur_last_ff;
  reg        final_pend_ff;
  reg [15:0] rx_data_ff;
  reg        rx_valid_ff;
  reg        empty_ff;
  reg        busy_ff;

  wire [3:0]  hd_pcs;
  wire        hd_last;
  wire [15:0] hd_data;
  reg  [3:0]  hd_lines;
  reg  [1:0]  hd_cfg;
  wire        hd_ok;
  wire [3:0]  hd_bits_raw;
  wire [4:0]  hd_nbits;
  wire [15:0] hd_aligned;

  // field from the word only in variable mode
  assign hd_pcs  = select_mode_bit_i ?
                   buf_data[`SPIMCS_SEL_MSB:`SPIMCS_SEL_LSB] :
                   slave_select_field_i;
  assign hd_last = select_mode_bit_i & buf_data[`SPIMCS_FINAL_BIT];
  assign hd_data = (~select_mode_bit_i & ~dma_halfword_i) ?
                   {8'h00, buf_data[7:0]} :
                   buf_data[`SPIMCS_TD_MSB:`SPIMCS_TD_LSB];

  always @* begin
    hd_lines = `SPIMCS_SEL_IDLE;
    hd_cfg   = 2'd0;
    if (select_decode_enable_i) begin
      hd_lines = hd_pcs;
      hd_cfg   = hd_pcs[3:2];
    end else if (!hd_pcs[0]) begin
      hd_lines = 4'hE;
      hd_cfg   = 2'd0;
    end else if (!hd_pcs[1]) begin
      hd_lines = 4'hD;
      hd_cfg   = 2'd1;
    end else if (!hd_pcs[2]) begin
      hd_lines = 4'hB;
      hd_cfg   = 2'd2;
    end else if (!hd_pcs[3]) begin
      hd_lines = 4'h7;
      hd_cfg   = 2'd3;
    end
  end

  // all ones names nobody: it is the idle code
  assign hd_ok = (hd_pcs != `SPIMCS_SEL_IDLE);

  assign hd_bits_raw = word_bits_i[{hd_cfg, 2'b00} +: 4];
  assign hd_nbits    = (hd_bits_raw > `SPIMCS_BITS_TOP) ? `SPIMCS_BITS_MAX :
                       (`SPIMCS_BITS_MIN + {1'b0, hd_bits_raw});
  // left-align so the msb always leaves from bit 15
  assign hd_aligned  = hd_data << (`SPIMCS_BITS_MAX - hd_nbits);

  wire        same_slave = hd_ok & (hd_lines == sel_ff);
  wire        cur_keep   = keep_select_active_i[cur_cfg_ff];
  wire        cur_force  = force_select_release_i[cur_cfg_ff];
  wire        done_last  = cur_last_ff | final_pend_ff;
  wire [7:0]  wgap_cur   = inter_word_delay_i[{cur_cfg_ff, 3'b000} +: 8];
  wire [8:0]  csgap      = ({1'b0, inter_select_delay_i} <
                            `SPIMCS_MIN_GAP_CYC) ? `SPIMCS_MIN_GAP_CYC :
                           {1'b0, inter_select_delay_i};

  //////////////////////////////////////////////////////////////////////////
  // sequencing

  reg [2:0] nxt_state;
  reg       do_load;
  reg       do_release;
  reg       do_drop;

  always @* begin
    nxt_state  = state_ff;
    do_load    = 1'b0;
    do_release = 1'b0;
    do_drop    = 1'b0;
    do_pop     = 1'b0;
    case (state_ff)
      `SPIMCS_ST_IDLE: begin
        if (enable_i & buf_valid) begin
          if (hd_ok) begin
            do_load = 1'b1;
          end else begin
            do_drop = 1'b1;
          end
        end
      end
      `SPIMCS_ST_LEAD: begin
        if (cnt_ff == 9'd0) begin
          nxt_state = `SPIMCS_ST_SHIFT;
        end
      end
      `SPIMCS_ST_SHIFT: begin
        if (cnt_ff == 9'd0 & sclk_ff & bit_ff == 5'd1) begin
          nxt_state = `SPIMCS_ST_WGAP;
        end
      end
      `SPIMCS_ST_WGAP: begin
        if (cnt_ff == 9'd0) begin
          if (done_last) begin
            do_release = 1'b1;
          end else if (buf_valid & same_slave) begin
            if (!cur_keep & cur_force) begin
              do_release = 1'b1;
            end else begin
              do_load = 1'b1;
            end
          end else if (buf_valid) begin
            do_release = 1'b1;
          end else if (cur_keep) begin
            nxt_state = `SPIMCS_ST_HOLD;
          end else begin
            do_release = 1'b1;
          end
        end
      end
      `SPIMCS_ST_HOLD: begin
        if (final_pend_ff) begin
          do_release = 1'b1;
        end else if (buf_valid & same_slave) begin
          do_load = 1'b1;
        end else if (buf_valid | ~enable_i) begin
          do_release = 1'b1;
        end
      end
      `SPIMCS_ST_CSGAP: begin
        if (cnt_ff == 9'd0) begin
          nxt_state = `SPIMCS_ST_IDLE;
        end
      end
      default: begin
        nxt_state = `SPIMCS_ST_IDLE;
      end
    endcase
    if (do_load) begin
      nxt_state = `SPIMCS_ST_LEAD;
    end
    if (do_release) begin
      nxt_state = `SPIMCS_ST_CSGAP;
    end
    do_pop = do_load | do_drop;
  end

  //////////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff      <= `SPIMCS_ST_IDLE;
      cnt_ff        <= 9'd0;
      sel_ff        <= `SPIMCS_SEL_IDLE;
      sclk_ff       <= 1'b0;
      mosi_ff       <= 1'b0;
      sh_ff         <= 16'h0000;
      rx_ff         <= 16'h0000;
      bit_ff        <= 5'd0;
      cur_cfg_ff    <= 2'd0;
      cur_last_ff   <= 1'b0;
      final_pend_ff <= 1'b0;
      rx_data_ff    <= 16'h0000;
      rx_valid_ff   <= 1'b0;
      empty_ff      <= 1'b1;
      busy_ff       <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      rx_valid_ff <= 1'b0;
      busy_ff     <= (nxt_state != `SPIMCS_ST_IDLE);
      empty_ff    <= buf_in_ready;
      if (cnt_ff != 9'd0) begin
        cnt_ff <= cnt_ff - 9'd1;
      end
      // set wins over the clear done by a release
      if (final_word_cmd_i) begin
        final_pend_ff <= 1'b1;
      end else if (do_release) begin
        final_pend_ff <= 1'b0;
      end
      if (do_load) begin
        sel_ff      <= hd_lines;
        cur_cfg_ff  <= hd_cfg;
        cur_last_ff <= hd_last;
        sh_ff       <= hd_aligned;
        mosi_ff     <= hd_aligned[15];
        bit_ff      <= hd_nbits;
        cnt_ff      <= `SPIMCS_HALF_CYC - 9'd1;
        sclk_ff     <= 1'b0;
      end else if (do_release) begin
        sel_ff      <= `SPIMCS_SEL_IDLE;
        cnt_ff      <= csgap - 9'd1;
        cur_last_ff <= 1'b0;
      end else if (state_ff == `SPIMCS_ST_LEAD & cnt_ff == 9'd0) begin
        cnt_ff <= `SPIMCS_HALF_CYC - 9'd1;
      end else if (state_ff == `SPIMCS_ST_SHIFT & cnt_ff == 9'd0) begin
        if (!sclk_ff) begin
          sclk_ff <= 1'b1;
          rx_ff   <= {rx_ff[14:0], miso_s};
          cnt_ff  <= `SPIMCS_HALF_CYC - 9'd1;
        end else begin
          sclk_ff <= 1'b0;
          bit_ff  <= bit_ff - 5'd1;
          if (bit_ff == 5'd1) begin
            rx_data_ff  <= rx_ff;
            rx_valid_ff <= 1'b1;
            cnt_ff      <= {1'b0, wgap_cur};
          end else begin
            sh_ff   <= {sh_ff[14:0], 1'b0};
            mosi_ff <= sh_ff[14];
            cnt_ff  <= `SPIMCS_HALF_CYC - 9'd1;
          end
        end
      end
    end
  end

  assign tx_ready_o         = buf_in_ready;
  assign tx_holding_empty_o = empty_ff;
  assign sclk_o             = sclk_ff;
  assign mosi_o             = mosi_ff;
  assign select_lines_o     = sel_ff;
  assign rx_data_o          = rx_data_ff;
  assign rx_valid_o         = rx_valid_ff;
  assign busy_o             = busy_ff;
endmodule
`default_nettype wire

// file: tb/spimcs_sva.sv
// port assertions for the chip-select control block
`timescale 1ns/1ns
`default_nettype none
module spimcs_sva (
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  input wire logic       select_mode_bit_i,
  input wire logic       select_decode_enable_i,
  input wire logic [3:0] slave_select_field_i,
  input wire logic [7:0] inter_select_delay_i,
  input wire logic       tx_ready_o,
  input wire logic       tx_holding_empty_o,
  input wire logic       sclk_o,
  input wire logic       mosi_o,
  input wire logic [3:0] select_lines_o,
  input wire logic       rx_valid_o,
  input wire logic       busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] f_cnt_ff;
  wire logic  idle_w = select_lines_o == 4'hF;
  // starts saturated so the first select after reset is not a gap
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i)
      f_cnt_ff <= 8'hFF;
    else if (!idle_w)
      f_cnt_ff <= 8'h00;
    else if (f_cnt_ff != 8'hFF)
      f_cnt_ff <= f_cnt_ff + 8'h01;
  end
  sequence s_high4; sclk_o [*4] ##1 !sclk_o; endsequence
  sequence s_reselect; idle_w ##1 !idle_w; endsequence
  property p_idle; !busy_o |-> idle_w; endproperty
  property p_one_low; !select_decode_enable_i |-> $onehot0(~select_lines_o);
  endproperty
  property p_raw; select_decode_enable_i && !select_mode_bit_i && !idle_w
    |-> select_lines_o == slave_select_field_i; endproperty
  property p_sclk_sel; sclk_o |-> !idle_w; endproperty
  property p_high; $rose(sclk_o) |-> s_high4; endproperty
  property p_mosi; sclk_o && $past(sclk_o) |-> $stable(mosi_o); endproperty
  property p_lines; sclk_o |-> $stable(select_lines_o); endproperty
  property p_gap; s_reselect |-> f_cnt_ff >=
    ((inter_select_delay_i == 8'h00) ? 8'h01 : inter_select_delay_i);
  endproperty
  property p_empty; $rose(tx_ready_o) |=> tx_holding_empty_o; endproperty
  property p_rx; rx_valid_o |=> !rx_valid_o; endproperty
  a_idle: assert property (p_idle)
    else $error("lines active while idle");
  a_one_low: assert property (p_one_low)
    else $error("more than one line low");
  a_raw: assert property (p_raw)
    else $error("decoded lines differ from field");
  a_sclk_sel: assert property (p_sclk_sel)
    else $error("serial clock without select");
  a_high: assert property (p_high)
    else $error("serial clock high phase wrong");
  a_mosi: assert property (p_mosi)
    else $error("mosi moved in high phase");
  a_lines: assert property (p_lines)
    else $error("lines moved in high phase");
  a_gap: assert property (p_gap)
    else $error("select gap too short");
  a_empty: assert property (p_empty)
    else $error("holding empty did not follow");
  a_rx: assert property (p_rx)
    else $error("rx valid longer than a cycle");
endmodule
bind spimcs_top spimcs_sva i_sva (.*);
`default_nettype wire

// file: tb/spimcs_slave.sv
// serial slave model: captures mosi, answers on miso in mode 0
`timescale 1ns/1ns
`default_nettype none
module spimcs_slave (
  input  wire logic        mclk_i,
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [15:0] reply_i,
  input  wire logic [4:0]  bits_i,
  output var  logic        miso_o,
  output var  logic [15:0] got_o
);
  logic [15:0] sr = 16'h0000;
  logic [4:0]  cnt = 5'h00;
  logic        sclk_q = 1'b0;
  logic        on_q = 1'b0;
  logic        wander = 1'b0;
  wire logic   on = sel_i != 4'hF;
  initial got_o = 16'h0000;
  // a released line must not hold its last level, so it toggles
  assign miso_o = on ? sr[15] : wander;
  always @(posedge mclk_i) begin
    wander <= ~wander;
    sclk_q <= sclk_i;
    on_q <= on;
    if (on && !on_q) begin
      sr <= reply_i << (5'h10 - bits_i);
      cnt <= 5'h00;
    end else if (sclk_i && !sclk_q) begin
      got_o <= {got_o[14:0], mosi_i};
      cnt <= cnt + 5'h01;
    end else if (!sclk_i && sclk_q) begin
      // reload for a following word under the same select
      if (cnt == bits_i) begin
        sr <= reply_i << (5'h10 - bits_i);
        cnt <= 5'h00;
      end else
        sr <= {sr[14:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

// file: tb/spimcs_top_bench.sv
// self-checking bench for the chip-select control block
`timescale 1ns/1ns
`default_nettype none
module spimcs_top_bench;
  typedef struct packed {
    logic [2:0]  cfg;
    logic [3:0]  sel;
    logic [3:0]  lines;
    logic [4:0]  bits;
    logic [15:0] data;
  } spimcs_row_t;
  logic mclk_i = 1'b0, resetn_i = 1'b0, enable_i = 1'b1;
  logic select_mode_bit_i = 1'b0, select_decode_enable_i = 1'b0;
  logic dma_halfword_i = 1'b0, final_word_cmd_i = 1'b0, tx_valid_i = 1'b0;
  logic [3:0] slave_select_field_i = 4'hE, keep_select_active_i = 4'h0;
  logic [3:0] force_select_release_i = 4'h0, select_lines_o;
  logic [7:0] inter_select_delay_i = 8'h03;
  logic [15:0] word_bits_i = 16'h8350, reply = 16'h0000, rx_data_o, got;
  logic [31:0] inter_word_delay_i = 32'h0202_0202, tx_data_i = 32'h0, m;
  logic tx_ready_o, tx_holding_empty_o, miso_i, sclk_o, mosi_o;
  logic rx_valid_o, busy_o;
  logic [4:0] bits = 5'h08;
  int failures = 0, compares = 0, rxn = 0, fgap = 0, i;
  spimcs_row_t r;
  // cfg is mode, decode, halfword
  spimcs_row_t rows [7] = '{
    '{3'h0, 4'hE, 4'hE, 5'h08, 16'h00A5}, '{3'h1, 4'hA, 4'hE, 5'h08, 16'h1234},
    '{3'h4, 4'h9, 4'hD, 5'h0D, 16'h1ABC}, '{3'h6, 4'h9, 4'h9, 5'h0B, 16'h0F0F},
    '{3'h6, 4'hE, 4'hE, 5'h10, 16'hC3A1}, '{3'h3, 4'h0, 4'h0, 5'h08, 16'h00FF},
    '{3'h4, 4'h7, 4'h7, 5'h10, 16'h8001}};
  always #4 mclk_i = ~mclk_i;
  spimcs_top i_dut (.*);
  spimcs_slave i_slave (.mclk_i(mclk_i), .sclk_i(sclk_o), .mosi_i(mosi_o),
    .sel_i(select_lines_o), .reply_i(reply), .bits_i(bits),
    .miso_o(miso_i), .got_o(got));
  always @(posedge mclk_i) begin
    if (rxn inside {[1:2]} && select_lines_o === 4'hF)
      fgap++;
    if (rx_valid_o === 1'b1)
      rxn++;
  end
  task check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out;
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // leaves valid high so back-to-back words need no idle cycle
  task push(input logic [31:0] w);
    tx_data_i = w;
    tx_valid_i = 1'b1;
    @(posedge mclk_i iff tx_ready_o === 1'b1);
    #1;
  endtask
  task idle_wait;
    @(posedge mclk_i iff busy_o === 1'b0);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #(8 * 20000);
    failures++;
    close_out;
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    #1 check("reset outputs", {select_lines_o, sclk_o, tx_ready_o,
      tx_holding_empty_o, busy_o}, 8'hF6);
    resetn_i = 1'b1;
    @(posedge mclk_i);
    #1;
    for (i = 0; i < 7; i++) begin
      r = rows[i];
      {select_mode_bit_i, select_decode_enable_i, dma_halfword_i} = r.cfg;
      // the unused field is set to disagree, proving it is ignored
      slave_select_field_i = r.cfg[2] ? 4'h3 : r.sel;
      bits = r.bits;
      reply = ~r.data;
      m = (32'h1 << r.bits) - 32'h1;
      push({12'h000, r.cfg[2] ? r.sel : 4'h3, r.data});
      tx_valid_i = 1'b0;
      @(posedge mclk_i iff select_lines_o !== 4'hF);
      #1 check("lines", select_lines_o, r.lines);
      @(posedge mclk_i iff rx_valid_o === 1'b1);
      #1 check("rx data", rx_data_o & m, reply & m);
      check("tx data", got & m, r.data & m);
      idle_wait;
      check("idle lines", select_lines_o, 4'hF);
    end
    {select_mode_bit_i, select_decode_enable_i, dma_halfword_i} = 3'h0;
    slave_select_field_i = 4'hE;
    bits = 5'h08;
    reply = 16'h3C3C;
    for (i = 0; i < 3; i++) begin
      // keep-active runs here with no mode-fault monitor left to switch off
      keep_select_active_i = {3'h0, i == 2};
      force_select_release_i = {3'h0, i != 0};
      rxn = 0;
      fgap = 0;
      push(32'h0000_0011);
      push(32'h0000_0022);
      push(32'h0000_0033);
      tx_valid_i = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1 check("full", {tx_ready_o, tx_holding_empty_o}, 2'b00);
      wait (rxn == 3);
      check("gap", fgap >= 6, i == 1);
      if (i == 2) begin
        repeat (40) @(posedge mclk_i);
        #1 check("held lines", select_lines_o, 4'hE);
        final_word_cmd_i = 1'b1;
        @(posedge mclk_i);
        #1 final_word_cmd_i = 1'b0;
      end
      idle_wait;
      check("released", select_lines_o, 4'hF);
    end
    select_mode_bit_i = 1'b1;
    slave_select_field_i = 4'h3;
    // a word naming the idle code is popped and dropped, nothing is selected
    push(32'h000F_1111);
    tx_valid_i = 1'b0;
    repeat (10) @(posedge mclk_i);
    #1 check("dropped", {busy_o, select_lines_o, tx_ready_o}, 6'h1F);
    rxn = 0;
    push(32'h010E_5A5A);
    tx_valid_i = 1'b0;
    wait (rxn == 1);
    repeat (30) @(posedge mclk_i);
    #1 check("final flag", {busy_o, select_lines_o}, 5'h0F);
    // reset in mid-word: all outputs drop back at once and the buffer empties
    push(32'h000E_0077);
    tx_valid_i = 1'b0;
    repeat (12) @(posedge mclk_i);
    #1 check("mid busy", {busy_o, select_lines_o}, 5'h1E);
    resetn_i = 1'b0;
    #1 check("mid reset", {select_lines_o, sclk_o, tx_ready_o,
      tx_holding_empty_o, busy_o}, 8'hF6);
    @(posedge mclk_i);
    #1 resetn_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    #1 check("after reset", {busy_o, select_lines_o}, 5'h0F);
    close_out;
  end
endmodule
`default_nettype wire
